// >>> shared/oau_consts.svh
`ifndef OAU_CONSTS_SVH
`define OAU_CONSTS_SVH
// =====================================================================
// Register map and field layout.
// =====================================================================
// Byte address of the automute control register.
`define OAU_CTRL_ADDR   4'h0
// Byte address of the read-only status register.
`define OAU_STAT_ADDR   4'h4
// Mode field position.
`define OAU_MODE_LSB    0
`define OAU_MODE_MSB    1
// First of the three mask bits (bits 4:2).
`define OAU_MASK_LSB    2
`define OAU_MASK_MSB    4
// Writable width of the control register.
`define OAU_CTRL_BITS   8
// Reset value of the control register.
`define OAU_CTRL_RST    8'h00
// AXI response codes.
`define OAU_RESP_OKAY   2'h0
`define OAU_RESP_SLVERR 2'h2
`endif

// >>> shared/oau_pkg.sv
// =====================================================================
// Types shared by the autounmute block.
// =====================================================================
package oau_pkg;
  // Autounmute mode selections.
  typedef enum logic [1:0] {
    OAU_MODE_OFF   = 2'b00,
    OAU_MODE_PROF  = 2'b01,
    OAU_MODE_PHASE = 2'b10,
    OAU_MODE_FREQ  = 2'b11
  } oau_mode_t;
endpackage : oau_pkg

// >>> hdl/oau_sync3.sv
`timescale 1ns/1ps
// =====================================================================
// Three-stage synchroniser; output changes once stages two and three agree.
// =====================================================================
module oau_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // Three stages per bit; first stage feeds only the second.
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Each bit is filtered on its own.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stage1_q[i] <= 1'b0;
          stage2_q[i] <= 1'b0;
          stage3_q[i] <= 1'b0;
          syncOut[i]  <= 1'b0;
        end else begin
          stage1_q[i] <= asyncIn[i];
          stage2_q[i] <= stage1_q[i];
          stage3_q[i] <= stage2_q[i];
          // Accept a change only when the last two stages agree.
          if (stage2_q[i] == stage3_q[i]) begin
            syncOut[i] <= stage3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule : oau_sync3

// >>> hdl/oau_output_autounmute.sv
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "oau_consts.svh"
module oau_output_autounmute
  import oau_pkg::*;
#(
  parameter int NOUT = 3
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [3:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [3:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            hitlessMode,
  input  wire logic            hitlessProfileActive,
  input  wire logic            phaseLockDetect,
  input  wire logic            frequencyLockDetect,
  output logic [NOUT-1:0]      driverEnable
);
  // ===================================================================
  // Status input synchronisation.
  // ===================================================================
  // Loop status comes from another domain and is filtered first.
  logic [3:0] statSync;
  oau_sync3 #(.WIDTH(4)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({frequencyLockDetect, phaseLockDetect,
               hitlessProfileActive, hitlessMode}),
    .syncOut (statSync)
  );
  logic hitlessS;   // Synchronised hitless mode.
  logic profileS;   // Synchronised hitless profile active.
  logic phaseS;     // Synchronised phase lock detect.
  logic freqS;      // Synchronised frequency lock detect.
  assign hitlessS = statSync[0];
  assign profileS = statSync[1];
  assign phaseS   = statSync[2];
  assign freqS    = statSync[3];

  // ===================================================================
  // Control register.
  // ===================================================================
  logic [`OAU_CTRL_BITS-1:0] ctrl_q;  // Mode, masks and spare bits.
  oau_mode_t                 mode;    // Decoded mode field.
  logic [NOUT-1:0]           mask;    // Per-output bypass bits.
  assign mode = oau_mode_t'(ctrl_q[`OAU_MODE_MSB:`OAU_MODE_LSB]);
  assign mask = ctrl_q[`OAU_MASK_LSB +: NOUT];

  // ===================================================================
  // AXI4-Lite write channel.
  // ===================================================================
  // Address and data are each held until both are present.
  logic        awHeld_q;
  logic [3:0]  awAddr_q;
  logic        wHeld_q;
  logic [31:0] wData_q;
  logic        wStrb0_q;  // Only byte lane zero carries register bits.
  logic        doWrite;
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  // Capture address and data in either order.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q  <= 1'b1;
        wData_q  <= s_axi_wdata;
        wStrb0_q <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Register update and write response; unmapped offsets get SLVERR.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q       <= `OAU_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OAU_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_q[3:2] == `OAU_CTRL_ADDR >> 2) begin
        s_axi_bresp <= `OAU_RESP_OKAY;
        if (wStrb0_q) begin
          ctrl_q <= wData_q[`OAU_CTRL_BITS-1:0];
        end
      end else if (awAddr_q[3:2] == `OAU_STAT_ADDR >> 2) begin
        // Status is read-only; the write is accepted and dropped.
        s_axi_bresp <= `OAU_RESP_OKAY;
      end else begin
        s_axi_bresp <= `OAU_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ===================================================================
  // AXI4-Lite read channel.
  // ===================================================================
  assign s_axi_arready = !s_axi_rvalid;

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OAU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `OAU_RESP_OKAY;
      if (s_axi_araddr[3:2] == `OAU_CTRL_ADDR >> 2) begin
        s_axi_rdata <= {24'h00_0000, ctrl_q};
      end else if (s_axi_araddr[3:2] == `OAU_STAT_ADDR >> 2) begin
        // Live view: enables in 2:0, status inputs in 7:4.
        s_axi_rdata <= {24'h00_0000, statSync, 1'b0, driverEnable};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `OAU_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ===================================================================
  // Unmute condition.
  // ===================================================================
  // The lock conditions count only while the channel is hitless.
  logic unmuteCond;
  always_comb begin
    case (mode)
      OAU_MODE_OFF:   unmuteCond = 1'b1;
      OAU_MODE_PROF:  unmuteCond = profileS;
      OAU_MODE_PHASE: unmuteCond = phaseS && hitlessS;
      OAU_MODE_FREQ:  unmuteCond = freqS && hitlessS;
      default:        unmuteCond = 1'b0;
    endcase
  end

  // Driver enables are registered so the pins see clean levels.
  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : g_out
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          driverEnable[g] <= 1'b0;
        end else begin
          // Mask bypasses the condition.
          driverEnable[g] <= mask[g] | unmuteCond;
        end
      end
    end
  endgenerate

  // ===================================================================
  // Checks.
  // ===================================================================
  // A reset edge clears the enables one cycle later, so every check that
  // looks one cycle ahead for an enable that may be set starts only on a cycle that is out of reset.
  chk_mask_bypass: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!sys_rst && mask[0]) |=> driverEnable[0])
    else $error("masked output not enabled");
  chk_off_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!sys_rst && mode == OAU_MODE_OFF) |=> &driverEnable)
    else $error("mode zero left a driver muted");
  chk_profile_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!sys_rst && mode == OAU_MODE_PROF && mask == '0) |=>
      driverEnable[0] == $past(profileS))
    else $error("profile mode mismatch");
  chk_phase_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode == OAU_MODE_PHASE && !mask[1] && !hitlessS) |=> !driverEnable[1])
    else $error("phase mode unmuted outside hitless");
  chk_freq_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!sys_rst && mode == OAU_MODE_FREQ && !mask[2]) |=>
      driverEnable[2] == $past(freqS && hitlessS))
    else $error("frequency mode mismatch");
  chk_clear_mask: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!mask[1] && !unmuteCond) |=> !driverEnable[1])
    else $error("unmasked output unmuted without cause");
  chk_or_enable: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> driverEnable[2] == $past(mask[2] | unmuteCond))
    else $error("enable is not mask or condition");
  // Checked on the first cycle out of reset, when the register has settled.
  chk_mode_reset: assert property (
    @(posedge clk) ($past(sys_rst) && !sys_rst) |-> ctrl_q == `OAU_CTRL_RST)
    else $error("control did not reset to zero");
endmodule : oau_output_autounmute

// >>> testbench/tb_output_autounmute_control.sv
`timescale 1ns/1ps
`include "oau_consts.svh"
module tb_output_autounmute_control
  import oau_pkg::*;
;
  // ====================================================================
  // Stimulus signals; all but clk driven by non-blocking assignment at posedge.
  // ====================================================================
  logic clk = 1'b0, sysRst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, stim = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] driverEnable;
  int n_mismatch = 0, comparisons = 0, seed = 32'h3B3F5D55;
  logic [1:0] wq[$];  // Expected write responses, oldest first.
  logic [33:0] rq[$]; // Expected {rresp, rdata}, oldest first.
  logic [2:0] eq[$];  // Expected driver enables, oldest first.
  always #5 clk = ~clk;
  oau_output_autounmute dut (.clk(clk), .sys_rst(sysRst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hitlessMode(stim[0]),
    .hitlessProfileActive(stim[1]), .phaseLockDetect(stim[2]),
    .frequencyLockDetect(stim[3]), .driverEnable(driverEnable));
  // ====================================================================
  // Reporting.
  // ====================================================================
  // One compare task per kind of result; unknowns count as mismatches.
  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] bresp expected %h seen %h", e, s);
    end
  endtask : cmp_resp
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] rdata expected %h seen %h", e, s);
    end
  endtask : cmp_rd
  task automatic cmp_en(input logic [2:0] e, input logic [2:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] driverEnable expected %h seen %h", e, s);
    end
  endtask : cmp_en
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Monitor: sampled at the falling edge, where combinational outputs have
  // settled to the values that the next rising edge will see.
  always @(negedge clk) begin
    if (bvalid && bready) cmp_resp(wq.pop_front(), bresp);
    if (rvalid && rready) cmp_rd(rq.pop_front(), {rresp, rdata});
    // An enable note is checked at the first falling edge after it is set.
    if (eq.size() != 0) cmp_en(eq.pop_front(), driverEnable);
  end
  // ====================================================================
  // AXI4-Lite master tasks; every wait is bounded.
  // ====================================================================
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    logic ah, wh, got;
    int n;
    wq.push_back(er);
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ah = 0; wh = 0; got = 0; n = 0;
    while (!got && n < 50) begin
      @(negedge clk);
      if (awvalid && awready) ah = 1;
      if (wvalid && wready) wh = 1;
      got = bvalid;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
      n++;
    end
    if (!got) begin n_mismatch++; final_report(); end
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [33:0] e);
    logic got;
    int n;
    rq.push_back(e);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    got = 0; n = 0;
    while (!got && n < 50) begin
      @(negedge clk);
      got = rvalid;
      if (arvalid && arready) begin @(posedge clk); arvalid <= 1'b0; end
      else @(posedge clk);
      if (got) rready <= 1'b0;
      n++;
    end
    if (!got) begin n_mismatch++; final_report(); end
  endtask : axr
  // Expected enables: mask bits OR the condition picked by the mode.
  function automatic logic [2:0] expEn(input logic [7:0] c,
                                       input logic [3:0] s);
    logic cond;
    case (oau_mode_t'(c[1:0]))
      OAU_MODE_OFF:   cond = 1'b1;
      OAU_MODE_PROF:  cond = s[1];
      OAU_MODE_PHASE: cond = s[0] & s[2];
      default:        cond = s[0] & s[3];
    endcase
    return c[4:2] | {3{cond}};
  endfunction : expEn
  // ====================================================================
  // Main sequence.
  // ====================================================================
  initial begin : mainSeq
    logic [7:0] c;
    logic [2:0] e;
    logic [31:0] d;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    axr(`OAU_CTRL_ADDR, {2'h0, 32'h0});
    eq.push_back(3'h7);
    // Every mode against every input combination, masks and spares random.
    for (int i = 0; i < 64; i++) begin
      d = $random(seed);
      d[1:0] = i[5:4];
      c = d[7:0];
      @(posedge clk) stim <= i[3:0];
      axw(`OAU_CTRL_ADDR, d, 4'h1, `OAU_RESP_OKAY);
      // Sync path plus register: five edges; eight leaves margin.
      repeat (8) @(posedge clk);
      e = expEn(c, stim);
      eq.push_back(e);
      axr(`OAU_CTRL_ADDR, {2'h0, 24'h0, c});
      axr(`OAU_STAT_ADDR, {2'h0, 24'h0, stim, 1'b0, e});
    end
    // Write with byte zero disabled leaves the control bits alone.
    axw(`OAU_CTRL_ADDR, 32'hFF, 4'hE, `OAU_RESP_OKAY);
    axr(`OAU_CTRL_ADDR, {2'h0, 24'h0, c});
    // Status is read only; unmapped places answer with an error.
    axw(`OAU_STAT_ADDR, 32'hFF, 4'hF, `OAU_RESP_OKAY);
    axw(4'h8, 32'hFF, 4'hF, `OAU_RESP_SLVERR);
    axr(4'h8, {`OAU_RESP_SLVERR, 32'h0});
    // Neither the dropped status write nor the refused one may have touched the control bits.
    axr(`OAU_CTRL_ADDR, {2'h0, 24'h0, c});
    // A reset in mid-run returns the mode to zero.
    axw(`OAU_CTRL_ADDR, 32'h03, 4'h1, `OAU_RESP_OKAY);
    @(posedge clk) sysRst <= 1'b1;
    @(posedge clk) sysRst <= 1'b0;
    axr(`OAU_CTRL_ADDR, {2'h0, 32'h0});
    eq.push_back(3'h7);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : tb_output_autounmute_control
